// file: hdl/hlc_pkg.sv
// Purpose: Constants and types for the headroom limiter configuration bank
// Assumes: Byte-wide control port with 16-bit register addresses
// Notes:   Offsets are byte addresses on the control port
package hlc_pkg;
  localparam logic [15:0] HLC_OFS_LIM     = 16'h20d2;
  localparam logic [15:0] HLC_OFS_MAXATN  = 16'h20d3;
  localparam logic [15:0] HLC_OFS_ATK     = 16'h20d4;
  localparam logic [15:0] HLC_OFS_RLS     = 16'h20d5;
  localparam logic [15:0] HLC_OFS_HYST    = 16'h20d6;
  localparam logic [15:0] HLC_OFS_EN      = 16'h20df;
  localparam logic [7:0]  HLC_RST_LIM     = 8'h00;
  localparam logic [4:0]  HLC_RST_MAXATN  = 5'h14;
  localparam logic [3:0]  HLC_RST_ATK     = 4'h2;
  localparam logic [3:0]  HLC_RST_RLS     = 4'h4;
  localparam logic [2:0]  HLC_RST_HYST    = 3'h3;
  localparam logic        HLC_RST_HYST_EN = 1'b1;
  localparam logic        HLC_RST_EN      = 1'b0;
  localparam logic [4:0]  HLC_THR_MAX     = 5'h0f;
  localparam logic [4:0]  HLC_ATN_MAX     = 5'h14;
  localparam logic [3:0]  HLC_ATK_MAX     = 4'hc;
  localparam logic [3:0]  HLC_RLS_MAX     = 4'hd;
  localparam int          HLC_THR_LSB     = 1;
  localparam int          HLC_HYST_LSB    = 1;
  localparam logic        HLC_MODE_DIST   = 1'b0;
  // Rate base times in ns per dB, clock period in ns, and base times in clock cycles per dB
  localparam longint      HLC_ATK_BASE_NS = 20000;
  localparam longint      HLC_RLS_BASE_NS = 2000000;
  localparam longint      HLC_CLK_NS      = 20;
  localparam int          HLC_ATK_BASE_CYC = int'(HLC_ATK_BASE_NS / HLC_CLK_NS);
  localparam int          HLC_RLS_BASE_CYC = int'(HLC_RLS_BASE_NS / HLC_CLK_NS);

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } hlc_req_t;

  typedef struct packed {
    logic        enable;
    logic        fixed_mode;
    logic [4:0]  threshold_db;
    logic [4:0]  max_atten_db;
    logic [31:0] attack_cyc_per_db;
    logic [31:0] release_cyc_per_db;
    logic        hyst_active;
    logic [3:0]  hyst_lsb;
  } hlc_cfg_t;
endpackage : hlc_pkg

// file: hdl/hlc_regs.sv
// Purpose: Register bank steering the headroom tracker
// Assumes: Control port request is synchronous to clk_in
// Notes:   Reserved codes are stored as written and decode to safe limits
`timescale 1ns/1ps
module hlc_regs (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rstn_in,
  // Control port
  input  wire hlc_pkg::hlc_req_t req_in,
  output logic [7:0]         rdata_out,
  output logic               hit_out,
  // Decoded configuration
  output hlc_pkg::hlc_cfg_t  cfg_out
);
  import hlc_pkg::*;

  // Decoded reset state, so cfg_out is legal from the first edge
  localparam hlc_cfg_t CFG_RST = '{
    enable:             HLC_RST_EN,
    fixed_mode:         (HLC_RST_LIM[0] != HLC_MODE_DIST),
    threshold_db:       5'h00,
    max_atten_db:       HLC_RST_MAXATN,
    attack_cyc_per_db:  32'(HLC_ATK_BASE_CYC) << HLC_RST_ATK,
    release_cyc_per_db: 32'(HLC_RLS_BASE_CYC) << HLC_RST_RLS,
    hyst_active:        HLC_RST_HYST_EN,
    hyst_lsb:           4'h4
  };

  logic [7:0] lim_r,    lim_nxt;
  logic [4:0] atn_r,    atn_nxt;
  logic [3:0] atk_r,    atk_nxt;
  logic [3:0] rls_r,    rls_nxt;
  logic [2:0] hyst_r,   hyst_nxt;
  logic       hyen_r,   hyen_nxt;
  logic       en_r,     en_nxt;
  logic [7:0] rdata_r,  rdata_nxt;
  hlc_cfg_t   cfg_r,    cfg_nxt;
  logic [4:0] thr_fld;

  // Register writes and readback
  always_comb begin
    lim_nxt   = lim_r;
    atn_nxt   = atn_r;
    atk_nxt   = atk_r;
    rls_nxt   = rls_r;
    hyst_nxt  = hyst_r;
    hyen_nxt  = hyen_r;
    en_nxt    = en_r;
    rdata_nxt = rdata_r;
    if (req_in.wr) begin
      case (req_in.addr)
        HLC_OFS_LIM:    lim_nxt  = {2'h0, req_in.wdata[5:0]};
        HLC_OFS_MAXATN: atn_nxt  = req_in.wdata[4:0];
        HLC_OFS_ATK:    atk_nxt  = req_in.wdata[3:0];
        HLC_OFS_RLS:    rls_nxt  = req_in.wdata[3:0];
        HLC_OFS_HYST: begin
          hyst_nxt = req_in.wdata[HLC_HYST_LSB +: 3];
          hyen_nxt = req_in.wdata[0];
        end
        HLC_OFS_EN:     en_nxt   = req_in.wdata[0];
        default:        en_nxt   = en_r;
      endcase
    end
    if (req_in.rd) begin
      case (req_in.addr)
        HLC_OFS_LIM:    rdata_nxt = lim_r;
        HLC_OFS_MAXATN: rdata_nxt = {3'h0, atn_r};
        HLC_OFS_ATK:    rdata_nxt = {4'h0, atk_r};
        HLC_OFS_RLS:    rdata_nxt = {4'h0, rls_r};
        HLC_OFS_HYST:   rdata_nxt = {4'h0, hyst_r, hyen_r};
        HLC_OFS_EN:     rdata_nxt = {7'h00, en_r};
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  // Decode of fields into tracker controls
  always_comb begin
    thr_fld                = lim_r[HLC_THR_LSB +: 5];
    cfg_nxt.enable         = en_r;
    cfg_nxt.fixed_mode     = (lim_r[0] != HLC_MODE_DIST);
    cfg_nxt.threshold_db   = 5'h00;
    if (cfg_nxt.fixed_mode) begin
      cfg_nxt.threshold_db = (thr_fld > HLC_THR_MAX) ? HLC_THR_MAX : thr_fld;
    end
    cfg_nxt.max_atten_db   = (atn_r == 5'h00 || atn_r > HLC_ATN_MAX) ? HLC_ATN_MAX : atn_r;
    cfg_nxt.attack_cyc_per_db = 32'(HLC_ATK_BASE_CYC) << ((atk_r > HLC_ATK_MAX) ? HLC_ATK_MAX : atk_r);
    cfg_nxt.release_cyc_per_db = 32'(HLC_RLS_BASE_CYC) << ((rls_r > HLC_RLS_MAX) ? HLC_RLS_MAX : rls_r);
    cfg_nxt.hyst_active    = hyen_r;
    case (hyst_r)
      3'h0:    cfg_nxt.hyst_lsb = 4'h1;
      3'h1:    cfg_nxt.hyst_lsb = 4'h2;
      3'h2:    cfg_nxt.hyst_lsb = 4'h3;
      3'h3:    cfg_nxt.hyst_lsb = 4'h4;
      3'h4:    cfg_nxt.hyst_lsb = 4'h6;
      3'h5:    cfg_nxt.hyst_lsb = 4'h8;
      3'h6:    cfg_nxt.hyst_lsb = 4'ha;
      default: cfg_nxt.hyst_lsb = 4'hc;
    endcase
    if (!hyen_r) begin
      cfg_nxt.hyst_lsb = 4'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      lim_r   <= HLC_RST_LIM;
      atn_r   <= HLC_RST_MAXATN;
      atk_r   <= HLC_RST_ATK;
      rls_r   <= HLC_RST_RLS;
      hyst_r  <= HLC_RST_HYST;
      hyen_r  <= HLC_RST_HYST_EN;
      en_r    <= HLC_RST_EN;
      rdata_r <= 8'h00;
      cfg_r   <= CFG_RST;
    end else begin
      lim_r   <= lim_nxt;
      atn_r   <= atn_nxt;
      atk_r   <= atk_nxt;
      rls_r   <= rls_nxt;
      hyst_r  <= hyst_nxt;
      hyen_r  <= hyen_nxt;
      en_r    <= en_nxt;
      rdata_r <= rdata_nxt;
      cfg_r   <= cfg_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign cfg_out   = cfg_r;
  assign hit_out   = (req_in.addr == HLC_OFS_LIM) || (req_in.addr == HLC_OFS_MAXATN) ||
                     (req_in.addr == HLC_OFS_ATK) || (req_in.addr == HLC_OFS_RLS) ||
                     (req_in.addr == HLC_OFS_HYST) || (req_in.addr == HLC_OFS_EN);

  // Checks
  en_follow_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_EN) |-> ##2 cfg_out.enable == $past(req_in.wdata[0], 2))
    else $error("enable did not follow write");
  thr_ignored_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !cfg_out.fixed_mode |-> cfg_out.threshold_db == 5'h00)
    else $error("threshold used in distortion mode");
  mode_pol_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_LIM) |-> ##2 cfg_out.fixed_mode == $past(req_in.wdata[0], 2))
    else $error("mode polarity wrong");
  thr_range_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cfg_out.threshold_db <= 5'h0f)
    else $error("threshold beyond -15dBFS");
  atn_cap_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cfg_out.max_atten_db >= 5'h01 && cfg_out.max_atten_db <= 5'h14)
    else $error("attenuation cap out of range");
  atk_rate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_ATK && req_in.wdata[3:0] == 4'h0) |->
    ##2 cfg_out.attack_cyc_per_db == 32'd1000)
    else $error("attack base rate wrong");
  rls_rate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_RLS && req_in.wdata[3:0] == 4'h1) |->
    ##2 cfg_out.release_cyc_per_db == 32'd200000)
    else $error("release rate wrong");
  hyst_max_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_HYST && req_in.wdata[3:0] == 4'hf) |->
    ##2 (cfg_out.hyst_lsb == 4'hc && cfg_out.hyst_active))
    else $error("hysteresis decode wrong");
  hyst_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !cfg_out.hyst_active |-> cfg_out.hyst_lsb == 4'h0)
    else $error("hysteresis applied while disabled");

  // Readback of a written register, one idle cycle between
  lim_back_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_LIM) ##1 !req_in.wr ##1 (req_in.rd && req_in.addr == HLC_OFS_LIM) |->
    ##1 rdata_out == {2'h0, $past(req_in.wdata[5:0], 3)})
    else $error("limiter register readback wrong");
  atn_back_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_MAXATN) ##1 !req_in.wr ##1 (req_in.rd && req_in.addr == HLC_OFS_MAXATN) |->
    ##1 rdata_out == {3'h0, $past(req_in.wdata[4:0], 3)})
    else $error("attenuation register readback wrong");
  atk_back_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_ATK) ##1 !req_in.wr ##1 (req_in.rd && req_in.addr == HLC_OFS_ATK) |->
    ##1 rdata_out == {4'h0, $past(req_in.wdata[3:0], 3)})
    else $error("attack register readback wrong");
  rls_back_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_RLS) ##1 !req_in.wr ##1 (req_in.rd && req_in.addr == HLC_OFS_RLS) |->
    ##1 rdata_out == {4'h0, $past(req_in.wdata[3:0], 3)})
    else $error("release register readback wrong");
  hyst_back_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_HYST) ##1 !req_in.wr ##1 (req_in.rd && req_in.addr == HLC_OFS_HYST) |->
    ##1 rdata_out == {4'h0, $past(req_in.wdata[3:0], 3)})
    else $error("hysteresis register readback wrong");
  en_back_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_EN) ##1 !req_in.wr ##1 (req_in.rd && req_in.addr == HLC_OFS_EN) |->
    ##1 rdata_out == {7'h00, $past(req_in.wdata[0], 3)})
    else $error("enable register readback wrong");

  // Decode of edge, middle and reserved codes; enable hold and reset state
  atn_clamp_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_MAXATN &&
     (req_in.wdata[4:0] == 5'h00 || req_in.wdata[4:0] > 5'h14)) |-> ##2 cfg_out.max_atten_db == 5'h14)
    else $error("reserved attenuation code not held at cap");
  atn_pass_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_MAXATN && req_in.wdata[4:0] inside {[5'h01:5'h14]}) |->
    ##2 cfg_out.max_atten_db == $past(req_in.wdata[4:0], 2))
    else $error("attenuation cap decode wrong");
  atk_clamp_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_ATK && req_in.wdata[3:0] >= 4'hc) |->
    ##2 cfg_out.attack_cyc_per_db == 32'd4096000)
    else $error("slowest attack rate wrong");
  rls_top_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_RLS && req_in.wdata[3:0] >= 4'hd) |->
    ##2 cfg_out.release_cyc_per_db == 32'd819200000)
    else $error("slowest release rate wrong");
  thr_fixed_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_LIM && req_in.wdata[0] && !req_in.wdata[5]) |->
    ##2 (cfg_out.fixed_mode && cfg_out.threshold_db == $past(req_in.wdata[5:1], 2)))
    else $error("fixed threshold decode wrong");
  thr_clamp_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_LIM && req_in.wdata[0] && req_in.wdata[5]) |->
    ##2 cfg_out.threshold_db == 5'h0f)
    else $error("reserved threshold not held at floor");
  hyst_min_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_HYST && req_in.wdata[3:0] == 4'h1) |->
    ##2 (cfg_out.hyst_lsb == 4'h1 && cfg_out.hyst_active))
    else $error("smallest hysteresis decode wrong");
  hyst_mid_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == HLC_OFS_HYST && req_in.wdata[3:0] == 4'h9) |->
    ##2 cfg_out.hyst_lsb == 4'h6)
    else $error("middle hysteresis decode wrong");
  en_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(req_in.wr && req_in.addr == HLC_OFS_EN) |-> ##2 $stable(cfg_out.enable))
    else $error("enable changed without a write");
  rst_vals_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(rstn_in) |-> (!cfg_out.enable && cfg_out.hyst_active && cfg_out.hyst_lsb == 4'h4 &&
      cfg_out.max_atten_db == 5'h14 && cfg_out.attack_cyc_per_db == 32'd4000 &&
      cfg_out.release_cyc_per_db == 32'd1600000))
    else $error("decoded reset state wrong");
endmodule : hlc_regs

// file: testbench/test_headroom_limiter_config.sv
// Purpose: Self-checking bench for the headroom limiter register bank
// Assumes: Requests driven at falling edge; model kept in bench arrays
// Notes:   Random upper bits check that unused bits are dropped
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module test_headroom_limiter_config;
  import hlc_pkg::*;
  logic             clk_in;
  logic             rstn_in;
  hlc_req_t         req;
  logic [7:0]       rdata_out;
  logic             hit_out;
  hlc_cfg_t         cfg_out;
  int               fail_count;
  int               checks_done;
  logic [7:0]       mdl [6];
  const logic [15:0] adr [6] = '{HLC_OFS_LIM, HLC_OFS_MAXATN, HLC_OFS_ATK, HLC_OFS_RLS, HLC_OFS_HYST, HLC_OFS_EN};
  const logic [7:0] msk [6] = '{8'h3f, 8'h1f, 8'h0f, 8'h0f, 8'h0f, 8'h01};
  const logic [7:0] rst [6] = '{8'h00, 8'h14, 8'h02, 8'h04, 8'h07, 8'h00};
  const logic [15:0] bad [4] = '{16'h20d1, 16'h20d7, 16'h20de, 16'h20e0};

  hlc_regs i_hlc_regs (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req), .rdata_out(rdata_out),
                       .hit_out(hit_out), .cfg_out(cfg_out));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  function automatic hlc_cfg_t exp_cfg();
    hlc_cfg_t c;
    int       t;
    int       ht [8] = '{1, 2, 3, 4, 6, 8, 10, 12};
    c.enable = mdl[5][0];
    c.fixed_mode = mdl[0][0];
    t = mdl[0][5:1];
    c.threshold_db = mdl[0][0] ? 5'(t > 15 ? 15 : t) : 5'h00;
    t = mdl[1][4:0];
    c.max_atten_db = 5'((t == 0 || t > 20) ? 20 : t);
    t = mdl[2][3:0];
    c.attack_cyc_per_db = 32'(1000 << (t > 12 ? 12 : t));
    t = mdl[3][3:0];
    c.release_cyc_per_db = 32'(100000 << (t > 13 ? 13 : t));
    c.hyst_active = mdl[4][0];
    c.hyst_lsb = mdl[4][0] ? 4'(ht[mdl[4][3:1]]) : 4'h0;
    return c;
  endfunction : exp_cfg

  task automatic put(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d, input logic h);
    req = '{w, r, a, d};
    #1 `CHK(hit_out, h)
    @(negedge clk_in);
    req = '{1'b0, 1'b0, a, d};
  endtask : put

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input logic h);
    put(1'b0, 1'b1, a, 8'h00, h);
    @(negedge clk_in);
    `CHK(rdata_out, e)
  endtask : rd_chk

  task automatic all_chk();
    @(negedge clk_in);
    `CHK(cfg_out, exp_cfg())
    for (int i = 0; i < 6; i++) rd_chk(adr[i], mdl[i], 1'b1);
  endtask : all_chk

  task automatic do_reset();
    rstn_in = 1'b0;
    mdl = rst;
    repeat (6) @(negedge clk_in);
    rstn_in = 1'b1;
    @(negedge clk_in);
    all_chk();
  endtask : do_reset

  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  initial begin
    logic [7:0] d;
    fail_count = 0;
    checks_done = 0;
    req = '0;
    rstn_in = 1'b0;
    void'($urandom(37));
    @(negedge clk_in);
    do_reset();
    for (int k = 0; k < 64; k++) begin
      for (int i = 0; i < 6; i++) begin
        d = {2'($urandom), 6'(k)};
        put(1'b1, 1'b0, adr[i], d, 1'b1);
        mdl[i] = d & msk[i];
        @(negedge clk_in);
        `CHK(cfg_out, exp_cfg())
        rd_chk(adr[i], mdl[i], 1'b1);
      end
    end
    for (int i = 0; i < 4; i++) begin
      put(1'b1, 1'b0, bad[i], 8'(~i), 1'b0);
      rd_chk(bad[i], 8'h00, 1'b0);
    end
    all_chk();
    do_reset();
    results();
  end

  initial begin
    #400000;
    fail_count++;
    results();
  end
endmodule : test_headroom_limiter_config
